// File: core/sca_pkg.sv
// Purpose: Shared constants and types for the serial clock access block
// Assumes: 25 MHz system clock, 32768 Hz oscillator sampled as a pin
// Notes: Offsets, field positions, reset values and counts live here
package sca_pkg;

  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int OSC_HZ = 32768;
  localparam int TEST_HZ = 512;
  localparam int TEST_HALF = OSC_HZ / (2 * TEST_HZ);
  localparam logic [4:0] TEST_HALF_LAST = 5'(TEST_HALF - 1);

  // ----------------------------------------
  // Calibration
  // ----------------------------------------
  localparam int CAL_SHORTEN = 128;
  localparam int CAL_LENGTHEN = 256;
  localparam int CAL_CYCLE_MIN = 64;
  localparam int CAL_WINDOW_MIN = 62;
  localparam int SECS_PER_MIN = 60;
  localparam logic [15:0] SEC_NOM_LAST = 16'(OSC_HZ - 1);
  localparam logic [15:0] SEC_SHORT_LAST = 16'(OSC_HZ - CAL_SHORTEN - 1);
  localparam logic [15:0] SEC_LONG_LAST = 16'(OSC_HZ + CAL_LENGTHEN - 1);
  localparam logic [5:0] SEC_IDX_LAST = 6'(SECS_PER_MIN - 1);
  localparam logic [5:0] MIN_IDX_LAST = 6'(CAL_CYCLE_MIN - 1);

  // ----------------------------------------
  // Memory map and control fields
  // ----------------------------------------
  localparam int RAM_DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam logic [5:0] CTRL_OFFSET = 6'h07;
  localparam int CAL_MAG_LSB = 0;
  localparam int CAL_MAG_W = 5;
  localparam int CAL_SIGN_BIT = 5;
  localparam int TEST_SELECT_BIT = 6;
  localparam int LEVEL_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = ADDR_W + 8;

  // ----------------------------------------
  // Serial slave states
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_DEV     = 4'h1,
    S_DEVACK  = 4'h3,
    S_WORD    = 4'h2,
    S_WORDACK = 4'h6,
    S_WDATA   = 4'h7,
    S_WDACK   = 4'h5,
    S_READ    = 4'hC,
    S_RACK    = 4'hD
  } sca_state_e;

endpackage

// File: core/sca_stream_if.sv
// Purpose: Valid/ready word carrier between the block's own modules
// Assumes: Word taken when valid and ready are both high
// Notes: src drives valid and data, snk drives ready
`timescale 1ns/1ns
`default_nettype none
interface sca_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // sca_stream_if
`default_nettype wire

// File: core/sca_fifo.sv
// Purpose: Synchronous FIFO for buffered write bytes
// Assumes: Single clock, synchronous active-high reset
// Notes: Depth must be a power of two
`timescale 1ns/1ns
`default_nettype none
module sca_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  sca_stream_if.snk wr,
  sca_stream_if.src rd
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("sca_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  wire logic full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire logic empty = (wrPtr == rdPtr);
  wire logic doPush = wr.valid && !full;
  wire logic doPop = rd.ready && !empty;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= wrPtr + (AW+1)'(doPush);
      rdPtr <= rdPtr + (AW+1)'(doPop);
    end
  end

endmodule // sca_fifo
`default_nettype wire

// File: core/sca_core.sv
// Purpose: Serial access, pointer, calibration and test pin of the clock RAM
// Assumes: scl, sda and osc pins are asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module sca_core #(
  parameter logic [6:0] DEV_ADDR = 7'h50, // Arbitrary bus address
  parameter int BUF_DEPTH = sca_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic oscPin,
  output logic testOut,
  output logic testOe,
  output logic secondTick
);
  import sca_pkg::*;

  generate
    if (BUF_DEPTH < 2) begin : g_bad_depth
      $error("sca_core buffer depth too small");
    end
  endgenerate

  // ----------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] oscSync;
  logic sclQ;
  logic sdaQ;
  logic oscQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      oscSync <= 2'h0;
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      oscQ <= 1'b0;
    end else begin
      sclSync <= {sclSync[0], sclPin};
      sdaSync <= {sdaSync[0], sdaIn};
      oscSync <= {oscSync[0], oscPin};
      sclQ <= sclSync[1];
      sdaQ <= sdaSync[1];
      oscQ <= oscSync[1];
    end
  end

  wire logic sclRise = sclSync[1] && !sclQ;
  wire logic sclFall = !sclSync[1] && sclQ;
  wire logic startCond = sclSync[1] && sclQ && sdaQ && !sdaSync[1];
  wire logic stopCond = sclSync[1] && sclQ && !sdaQ && sdaSync[1];
  wire logic oscRise = oscSync[1] && !oscQ;

  // ----------------------------------------
  // Memory, control register and write buffer
  // ----------------------------------------
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] ctrl;
  logic [ADDR_W-1:0] ptr;
  logic loadEvt;

  sca_stream_if #(.W(FIFO_W)) pushIf ();
  sca_stream_if #(.W(FIFO_W)) drainIf ();

  sca_fifo #(.W(FIFO_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .rst(rst),
    .wr(pushIf.snk),
    .rd(drainIf.src)
  );

  function automatic logic [7:0] fetch(input logic [ADDR_W-1:0] a, input logic [7:0] c, input logic [7:0] m);
    fetch = (a == CTRL_OFFSET) ? c : m;
  endfunction

  wire logic [ADDR_W-1:0] ptrNext = ptr + 6'h01;
  wire logic [7:0] curByte = fetch(ptr, ctrl, ram[ptr]);
  wire logic [7:0] nextByte = fetch(ptrNext, ctrl, ram[ptrNext]);
  wire logic [ADDR_W-1:0] drainAddr = drainIf.data[FIFO_W-1:8];
  wire logic [7:0] drainByte = drainIf.data[7:0];
  wire logic ramWr = drainIf.valid && drainIf.ready;

  // Single-port RAM: a read fetch stalls draining
  assign drainIf.ready = !loadEvt;

  always_ff @(posedge clk) begin
    if (ramWr) begin
      ram[drainAddr] <= drainByte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (ramWr && drainAddr == CTRL_OFFSET) begin
      ctrl <= drainByte;
    end
  end

  // ----------------------------------------
  // Serial slave
  // ----------------------------------------
  sca_state_e state;
  sca_state_e next_state;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] next_shiftIn;
  logic [7:0] txShift;
  logic [7:0] next_txShift;
  logic [ADDR_W-1:0] next_ptr;
  logic next_sdaOe;
  logic masterAck;
  logic next_masterAck;
  logic pushValid;

  wire logic byteDone = sclFall && bitCnt == 4'h8;
  wire logic addrMatch = shiftIn[7:1] == DEV_ADDR;

  assign pushIf.valid = pushValid;
  assign pushIf.data = {ptr, shiftIn};

  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_shiftIn = shiftIn;
    next_txShift = txShift;
    next_ptr = ptr;
    next_sdaOe = sdaOe;
    next_masterAck = masterAck;
    loadEvt = 1'b0;
    pushValid = 1'b0;
    if (stopCond) begin
      next_state = S_IDLE;
      next_sdaOe = 1'b0;
    end else if (startCond) begin
      next_state = S_DEV;
      next_bitCnt = 4'h0;
      next_sdaOe = 1'b0;
    end else if ((state == S_DEV || state == S_WORD || state == S_WDATA) && sclRise && bitCnt != 4'h8) begin
      next_shiftIn = {shiftIn[6:0], sdaSync[1]};
      next_bitCnt = bitCnt + 4'h1;
    end else begin
      case (state)
        S_DEV: begin
          if (byteDone) begin
            next_state = addrMatch ? S_DEVACK : S_IDLE;
            next_sdaOe = addrMatch;
          end
        end
        S_DEVACK: begin
          if (sclFall && shiftIn[0]) begin
            next_state = S_READ;
            loadEvt = 1'b1;
            next_txShift = curByte;
            next_sdaOe = !curByte[7];
            next_bitCnt = 4'h0;
          end else if (sclFall) begin
            next_state = S_WORD;
            next_sdaOe = 1'b0;
            next_bitCnt = 4'h0;
          end
        end
        S_WORD: begin
          if (byteDone) begin
            next_ptr = shiftIn[ADDR_W-1:0];
            next_state = S_WORDACK;
            next_sdaOe = 1'b1;
          end
        end
        S_WORDACK, S_WDACK: begin
          if (sclFall) begin
            next_state = S_WDATA;
            next_sdaOe = 1'b0;
            next_bitCnt = 4'h0;
            if (state == S_WDACK) begin
              next_ptr = ptrNext;
            end
          end
        end
        S_WDATA: begin
          if (byteDone) begin
            pushValid = pushIf.ready;
            next_state = pushIf.ready ? S_WDACK : S_IDLE;
            next_sdaOe = pushIf.ready;
          end
        end
        S_READ: begin
          if (sclRise) begin
            next_bitCnt = bitCnt + 4'h1;
          end else if (byteDone) begin
            next_state = S_RACK;
            next_sdaOe = 1'b0;
          end else if (sclFall) begin
            next_txShift = {txShift[6:0], 1'b0};
            next_sdaOe = !txShift[6];
          end
        end
        S_RACK: begin
          if (sclRise) begin
            next_masterAck = !sdaSync[1];
          end else if (sclFall && masterAck) begin
            next_ptr = ptrNext;
            loadEvt = 1'b1;
            next_txShift = nextByte;
            next_sdaOe = !nextByte[7];
            next_bitCnt = 4'h0;
            next_state = S_READ;
          end else if (sclFall) begin
            next_state = S_IDLE;
          end
        end
        default: begin
          next_state = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      bitCnt <= 4'h0;
      shiftIn <= 8'h00;
      txShift <= 8'h00;
      ptr <= '0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      masterAck <= 1'b0;
    end else begin
      state <= next_state;
      bitCnt <= next_bitCnt;
      shiftIn <= next_shiftIn;
      txShift <= next_txShift;
      ptr <= next_ptr;
      sdaOe <= next_sdaOe;
      sdaOut <= 1'b0;
      masterAck <= next_masterAck;
    end
  end

  // ----------------------------------------
  // Divider chain with calibration
  // ----------------------------------------
  logic [15:0] tickCnt;
  logic [5:0] secIdx;
  logic [5:0] minIdx;
  logic [4:0] halfCnt;
  logic testPhase;

  wire logic [4:0] calMag = ctrl[CAL_MAG_LSB +: CAL_MAG_W];
  wire logic calSign = ctrl[CAL_SIGN_BIT];
  wire logic testMode = ctrl[TEST_SELECT_BIT];
  wire logic corrActive = (secIdx == 6'h00) && (minIdx < {calMag, 1'b0});
  // Positive splits half a /256 period out, negative blanks a whole one
  wire logic [15:0] secLast = !corrActive ? SEC_NOM_LAST : (calSign ? SEC_SHORT_LAST : SEC_LONG_LAST);
  wire logic secWrap = oscRise && tickCnt == secLast;
  wire logic halfWrap = oscRise && halfCnt == TEST_HALF_LAST;
  wire logic next_testOe = testMode ? !testPhase : !ctrl[LEVEL_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      tickCnt <= 16'h0000;
      secIdx <= 6'h00;
      minIdx <= 6'h00;
      secondTick <= 1'b0;
    end else begin
      secondTick <= secWrap;
      if (oscRise) begin
        tickCnt <= secWrap ? 16'h0000 : tickCnt + 16'h0001;
      end
      if (secWrap) begin
        secIdx <= (secIdx == SEC_IDX_LAST) ? 6'h00 : secIdx + 6'h01;
      end
      if (secWrap && secIdx == SEC_IDX_LAST) begin
        minIdx <= (minIdx == MIN_IDX_LAST) ? 6'h00 : minIdx + 6'h01;
      end
    end
  end

  // Test divider runs from raw oscillator edges only
  always_ff @(posedge clk) begin
    if (rst) begin
      halfCnt <= 5'h00;
      testPhase <= 1'b0;
      testOe <= 1'b0;
      testOut <= 1'b0;
    end else begin
      halfCnt <= halfWrap ? 5'h00 : halfCnt + 5'(oscRise);
      testPhase <= testPhase ^ halfWrap;
      testOe <= next_testOe;
      testOut <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_word_load;
    @(posedge clk) disable iff (rst) (state == S_WORD && byteDone && !startCond && !stopCond)
      |=> ptr == $past(shiftIn[ADDR_W-1:0]) && state == S_WORDACK;
  endproperty
  a_word_load: assert property (p_word_load) else $error("word address not loaded");

  property p_write_step;
    @(posedge clk) disable iff (rst) (state == S_WDACK && sclFall && !startCond && !stopCond)
      |=> ptr == $past(ptrNext) && state == S_WDATA;
  endproperty
  a_write_step: assert property (p_write_step) else $error("write pointer did not step");

  property p_ack_drive;
    @(posedge clk) disable iff (rst) (state == S_DEVACK || state == S_WORDACK || state == S_WDACK) |-> sdaOe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");

  property p_read_hold;
    @(posedge clk) disable iff (rst) (state == S_RACK && sclFall && !masterAck && !startCond && !stopCond)
      |=> ptr == $past(ptr) && state == S_IDLE;
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("pointer moved without acknowledge");

  property p_read_next;
    @(posedge clk) disable iff (rst) (state == S_RACK && sclFall && masterAck && !startCond && !stopCond)
      |=> state == S_READ && txShift == $past(nextByte) && sdaOe == !$past(nextByte[7]);
  endproperty
  a_read_next: assert property (p_read_next) else $error("next read byte not presented");

  property p_wrap;
    @(posedge clk) disable iff (rst) (ptr == 6'h3F && next_ptr != ptr && !(state == S_WORD)) |=> ptr == 6'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_window;
    @(posedge clk) disable iff (rst) corrActive |-> minIdx < 6'h3E && minIdx < {calMag, 1'b0} && secIdx == 6'h00;
  endproperty
  a_window: assert property (p_window) else $error("correction outside window");

  property p_sec_len;
    @(posedge clk) disable iff (rst) secondTick |-> $past(tickCnt) == 16'h7FFF || $past(tickCnt) == 16'h7F7F
      || $past(tickCnt) == 16'h80FF;
  endproperty
  a_sec_len: assert property (p_sec_len) else $error("second length wrong");

  property p_test_toggle;
    @(posedge clk) disable iff (rst) (testMode && halfWrap) ##1 testMode[*2] |-> testOe != $past(testOe);
  endproperty
  a_test_toggle: assert property (p_test_toggle) else $error("test pin did not toggle");

  property p_level;
    @(posedge clk) disable iff (rst) (!testMode ##1 !testMode) |-> testOe == !$past(ctrl[LEVEL_BIT]);
  endproperty
  a_level: assert property (p_level) else $error("pin does not follow level bit");

  property p_ctrl_write;
    @(posedge clk) disable iff (rst) (ramWr && drainAddr == 6'h07) |=> ctrl == $past(drainByte);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control register not written");

endmodule // sca_core
`default_nettype wire

// File: verif/sca_bus_master.sv
// Purpose: Behavioural two-wire bus master that faces the serial clock block
// Assumes: Open-drain data line with pull-up resolved by the bench
// Notes: Tasks are called from the bench; extra slows the first two phases of every bit
`timescale 1ns/1ns
`default_nettype none
module sca_bus_master #(
  parameter int Q = 5
) (
  input wire logic clk,
  output logic sclPin,
  output logic sdaLow,
  input wire logic sdaLine,
  output logic rdValid,
  output logic [7:0] rdData
);
  int extra = 0;

  initial begin
    sclPin = 1'b1;
    sdaLow = 1'b0;
    rdValid = 1'b0;
    rdData = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  // Also serves as repeated start from a low clock
  task automatic start_cond();
    sdaLow = 1'b0;
    tick(Q);
    sclPin = 1'b1;
    tick(Q);
    sdaLow = 1'b1;
    tick(Q);
    sclPin = 1'b0;
    tick(Q);
  endtask

  task automatic stop_cond();
    sdaLow = 1'b1;
    tick(Q);
    sclPin = 1'b1;
    tick(Q);
    sdaLow = 1'b0;
    tick(Q);
  endtask

  // ----------------------------------------
  // Bit and byte transfers
  // ----------------------------------------
  task automatic clk_bit(input logic b, output logic s);
    sdaLow = !b;
    tick(Q + extra);
    sclPin = 1'b1;
    tick(Q + extra);
    s = sdaLine;
    tick(Q);
    sclPin = 1'b0;
    tick(Q);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = !s;
  endtask

  // Last byte of a read is left unacknowledged by the caller
  task automatic recv_byte(input logic mack);
    logic [7:0] v;
    logic s;
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      clk_bit(1'b1, s);
      v = {v[6:0], s};
    end
    clk_bit(!mack, s);
    rdData = v;
    rdValid = 1'b1;
    tick(1);
    rdValid = 1'b0;
  endtask
endmodule // sca_bus_master
`default_nettype wire

// File: verif/test_serial_clock_access_and_calibration.sv
// Purpose: Self-checking bench for the serial clock access block
// Assumes: Default bus address and buffer depth of the core
// Notes: Read bytes are checked by a watcher against a queue of expectations
`timescale 1ns/1ns
`default_nettype none
module test_serial_clock_access_and_calibration;
  import sca_pkg::*;
  localparam logic [6:0] DEV = 7'h50;
  localparam int HALF_EDGES = OSC_HZ / (2 * TEST_HZ);
  // Oscillator rises counted in reset before the first second starts and in synchroniser lag after it ends
  localparam int OSC_LAG = 6;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic oscPin = 1'b0;
  logic sclPin, sdaLow, sdaOe, testOe, rdValid, sdaIn;
  logic sdaOut, testOut, secondTick;
  logic [7:0] rdData;
  logic [7:0] mem [RAM_DEPTH];
  logic [7:0] expQ [$];
  logic [5:0] ptr;
  int fails = 0;
  int comparisons = 0;
  int oscEdges = 0;

  assign sdaIn = !(sdaOe || sdaLow);

  always #20 clk = ~clk;

  // Oscillator sped up to one level per clock so a whole second fits the run
  always begin
    @(posedge clk);
    #1;
    oscPin = ~oscPin;
    if (oscPin) oscEdges++;
  end

  sca_core i_sca_core (.clk(clk), .rst(rst), .sclPin(sclPin), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .oscPin(oscPin), .testOut(testOut), .testOe(testOe), .secondTick(secondTick));

  sca_bus_master i_sca_bus_master (.clk(clk), .sclPin(sclPin), .sdaLow(sdaLow), .sdaLine(sdaIn),
    .rdValid(rdValid), .rdData(rdData));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic check_bit(input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic check_count(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        fails++;
        $display("[ERR] t=%0t exp=none got=%h", $time, rdData);
      end else begin
        check_byte(expQ.pop_front(), rdData);
      end
    end
  end

  // ----------------------------------------
  // Bus transactions
  // ----------------------------------------
  task automatic set_ptr(input logic [5:0] a);
    logic ack;
    i_sca_bus_master.start_cond();
    i_sca_bus_master.send_byte({DEV, 1'b0}, ack);
    check_bit(1'b1, ack);
    i_sca_bus_master.send_byte({2'b00, a}, ack);
    check_bit(1'b1, ack);
  endtask

  task automatic write_seq(input logic [5:0] a, input logic [7:0] d [$]);
    logic ack;
    set_ptr(a);
    for (int i = 0; i < d.size(); i++) begin
      i_sca_bus_master.send_byte(d[i], ack);
      check_bit(1'b1, ack);
      mem[6'(a + i)] = d[i];
    end
    ptr = 6'(a + d.size());
    i_sca_bus_master.stop_cond();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic read_seq(input logic [5:0] a, input logic useAddr, input int n);
    logic ack;
    logic [5:0] p;
    p = useAddr ? a : ptr;
    if (useAddr) set_ptr(a);
    i_sca_bus_master.start_cond();
    i_sca_bus_master.send_byte({DEV, 1'b1}, ack);
    check_bit(1'b1, ack);
    for (int i = 0; i < n; i++) begin
      expQ.push_back(mem[6'(p + i)]);
      i_sca_bus_master.recv_byte(i < n - 1);
    end
    ptr = 6'(p + n - 1);
    i_sca_bus_master.stop_cond();
  endtask

  task automatic wait_change(output int e);
    logic prev;
    int i;
    prev = testOe;
    for (i = 0; i < 2000 && testOe === prev; i++) begin
      @(posedge clk);
      #2;
    end
    if (i >= 2000) begin
      fails++;
      report_and_stop();
    end else begin
      e = oscEdges;
    end
  endtask

  task automatic wait_second(output int e);
    int i;
    for (i = 0; i < 70000 && secondTick !== 1'b1; i++) begin
      @(posedge clk);
      #2;
    end
    if (i >= 70000) begin
      fails++;
      report_and_stop();
    end else begin
      e = oscEdges;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] d [$];
    logic ack;
    int e0, e1, e2;
    void'($urandom(62465));
    mem[CTRL_OFFSET] = CTRL_RESET;
    ptr = 6'h00;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check_bit(1'b0, testOe);
    // Burst across the top of the space, then read it back
    for (int k = 0; k < 6; k++) d.push_back(8'($urandom));
    write_seq(6'h3C, d);
    read_seq(6'h3C, 1'b1, 6);
    read_seq(6'h00, 1'b0, 1);
    // Foreign bus address is not acknowledged
    i_sca_bus_master.start_cond();
    i_sca_bus_master.send_byte({DEV ^ 7'h01, 1'b0}, ack);
    check_bit(1'b0, ack);
    i_sca_bus_master.stop_cond();
    // Level bit drives the pin, read back slowly
    write_seq(CTRL_OFFSET, {8'h00});
    check_bit(1'b1, testOe);
    i_sca_bus_master.extra = 6;
    read_seq(CTRL_OFFSET, 1'b1, 1);
    i_sca_bus_master.extra = 0;
    write_seq(CTRL_OFFSET, {8'h80});
    check_bit(1'b0, testOe);
    // Test frequency with varying calibration
    for (int k = 0; k < 3; k++) begin
      write_seq(CTRL_OFFSET, {8'h40 | 8'($urandom_range(63))});
      wait_change(e0);
      wait_change(e1);
      wait_change(e2);
      check_byte(8'(HALF_EDGES), 8'(e1 - e0));
      check_byte(8'(HALF_EDGES), 8'(e2 - e1));
    end
    // First second after reset is second zero of minute zero, so it is corrected
    write_seq(CTRL_OFFSET, {8'h80 | 8'($urandom_range(31, 1)) | (8'($urandom_range(1)) << CAL_SIGN_BIT)});
    wait_second(e0);
    check_count(32'(OSC_LAG + (mem[CTRL_OFFSET][CAL_SIGN_BIT] ? OSC_HZ - CAL_SHORTEN : OSC_HZ + CAL_LENGTHEN)),
      32'(e0));
    check_bit(1'b0, sdaOut);
    check_bit(1'b0, testOut);
    repeat (4) @(posedge clk);
    check_bit(1'b1, expQ.size() == 0);
    report_and_stop();
  end
endmodule // test_serial_clock_access_and_calibration
`default_nettype wire
